// ---- dem_pkg.sv ----
/*
  Package for the DMA event channel mapper: register map, field layout,
  reset codes, event codes and the carrier structs.
  Assumes a 32-bit AHB-Lite register bus and sixteen DMA channels.
*/
package dem_pkg;

  localparam int NUM_CH = 16;
  localparam int CODE_W = 6;
  localparam int NUM_EVT = 13;

  // Register byte addresses
  localparam logic [31:0] EVENT_MAP_CH0_3_ADDR = 32'h01a0ff00;
  localparam logic [31:0] EVENT_MAP_CH4_7_ADDR = 32'h01a0ff04;
  localparam logic [31:0] EVENT_MAP_CH12_15_ADDR = 32'h01a0ff0c;
  localparam logic [31:0] MAPPER_CTRL_ADDR = 32'h01a0ff10;

  // Code field positions inside a selector register
  localparam int FIELD0_LSB = 0;
  localparam int FIELD_STRIDE = 8;
  localparam logic [31:0] FIELD_MASK = 32'h3f3f3f3f;

  // Chaining channels and their completion codes
  localparam int CHAIN_FIRST = 8;
  localparam int CHAIN_LAST = 11;
  localparam logic [3:0] CHAIN_CODE_FIRST = 4'h8;

  // Event codes
  localparam logic [5:0] EV_HOST = 6'h00;
  localparam logic [5:0] EV_TIMER0 = 6'h01;
  localparam logic [5:0] EV_TIMER1 = 6'h02;
  localparam logic [5:0] EV_SDRAM = 6'h03;
  localparam logic [5:0] EV_GPIO4 = 6'h04;
  localparam logic [5:0] EV_GPIO5 = 6'h05;
  localparam logic [5:0] EV_GPIO6 = 6'h06;
  localparam logic [5:0] EV_GPIO7 = 6'h07;
  localparam logic [5:0] EV_GPIO2 = 6'h0a;
  localparam logic [5:0] EV_SER0_TX = 6'h0c;
  localparam logic [5:0] EV_SER0_RX = 6'h0d;
  localparam logic [5:0] EV_SER1_TX = 6'h0e;
  localparam logic [5:0] EV_SER1_RX = 6'h0f;

  // Reset value of the mode register: 0 selects the fixed mapping
  localparam logic MODE_SELECTABLE_RST = 1'b1;

  typedef struct packed {
    logic serial1_rx_event;
    logic serial1_tx_event;
    logic serial0_rx_event;
    logic serial0_tx_event;
    logic gpio_pin2_event;
    logic gpio_pin7_event;
    logic gpio_pin6_event;
    logic gpio_pin5_event;
    logic gpio_pin4_event;
    logic sdram_refresh_event;
    logic timer_one_event;
    logic timer_zero_event;
    logic host_port_event;
  } dem_events_s;

  typedef struct packed {
    logic valid;
    logic [3:0] completion_code;
  } dem_chain_s;

endpackage

// ---- dem_code_regs.sv ----
/*
  Selector register file: three 32-bit registers holding four 6-bit
  channel codes each, with write strobes and registered read data.
  Assumes writes arrive already decoded from the bus on SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module dem_code_regs (
  input wire logic clk,          // System clock
  input wire logic rst,          // Synchronous reset, active high
  input wire logic [2:0] wr_sel, // One-hot register write select
  input wire logic [31:0] wdata, // Write data
  input wire logic [1:0] rd_idx, // Register read index
  output logic [31:0] rdata,     // Registered read data
  output logic [95:0] codes      // All three registers, ascending
);

  logic [95:0] regs_q;
  logic [95:0] regs_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Each field resets to its own channel number
  function automatic logic [31:0] reset_word(input int first_ch);
    logic [31:0] w;
    w = '0;
    for (int f = 0; f < 4; f++) begin
      w[f*dem_pkg::FIELD_STRIDE +: dem_pkg::CODE_W] = 6'(first_ch + f);
    end
    return w;
  endfunction

  localparam logic [95:0] REGS_RST = {reset_word(12), reset_word(4), reset_word(0)};

  always_comb begin
    regs_d = regs_q;
    for (int r = 0; r < 3; r++) begin
      if (wr_sel[r]) begin
        regs_d[r*32 +: 32] = wdata & dem_pkg::FIELD_MASK;
      end
    end
    // Read the next value, so a read riding a write's data phase sees that write
    rdata_d = (rd_idx < 2'd3) ? regs_d[rd_idx*32 +: 32] : 32'h00000000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regs_q <= REGS_RST;
      rdata_q <= 32'h00000000;
    end else begin
      regs_q <= regs_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign codes = regs_q;

endmodule

`default_nettype wire

// ---- dem_event_decode.sv ----
/*
  Turns one 6-bit event code into a trigger, given the current event
  pulses. Reserved codes never trigger.
  Assumes event inputs are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dem_event_decode (
  input wire logic [5:0] code,                // Selected event code
  input wire dem_pkg::dem_events_s events,    // Current event pulses
  output logic hit                            // Selected event is active
);

  always_comb begin
    case (code)
      dem_pkg::EV_HOST: hit = events.host_port_event;
      dem_pkg::EV_TIMER0: hit = events.timer_zero_event;
      dem_pkg::EV_TIMER1: hit = events.timer_one_event;
      dem_pkg::EV_SDRAM: hit = events.sdram_refresh_event;
      dem_pkg::EV_GPIO4: hit = events.gpio_pin4_event;
      dem_pkg::EV_GPIO5: hit = events.gpio_pin5_event;
      dem_pkg::EV_GPIO6: hit = events.gpio_pin6_event;
      dem_pkg::EV_GPIO7: hit = events.gpio_pin7_event;
      dem_pkg::EV_GPIO2: hit = events.gpio_pin2_event;
      dem_pkg::EV_SER0_TX: hit = events.serial0_tx_event;
      dem_pkg::EV_SER0_RX: hit = events.serial0_rx_event;
      dem_pkg::EV_SER1_TX: hit = events.serial1_tx_event;
      dem_pkg::EV_SER1_RX: hit = events.serial1_rx_event;
      default: hit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ---- dem_mapper.sv ----
/*
  DMA event channel mapper: routes peripheral events onto sixteen DMA
  channel triggers, fixed or through software selector registers
  reached over AHB-Lite. Assumes event and completion inputs are
  single-cycle pulses synchronous to SYS_CLK.
*/
// Contract
// - Sixteen channel trigger outputs, one line per channel 0 to 15.
// - Channels 8-11 fire only on completion codes 1000b-1011b; no selector.
// - Fixed mode: each channel takes only its own default event.
// - Selectable mode: channel fires on the event whose code its field holds.
// - Four 6-bit fields per register at 5:0, 13:8, 21:16, 29:24.
// - Fields reset to their own channel number.
// - Event code decoding table; other codes reserved.
// - Selector registers at 0x01a0ff00, 0x01a0ff04, 0x01a0ff0c.
// - Pin events 4 to 7 come from the GPIO block's interrupt pins.
// - Reserved register bits read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none

module dem_mapper (
  input wire logic SYS_CLK,                   // System clock, 10 MHz
  input wire logic RST,                       // Synchronous reset, active high
  input wire logic HSEL,                      // AHB slave select
  input wire logic [31:0] HADDR,              // AHB address
  input wire logic [1:0] HTRANS,              // AHB transfer type
  input wire logic HWRITE,                    // AHB write
  input wire logic [2:0] HSIZE,               // AHB size
  input wire logic [31:0] HWDATA,             // AHB write data
  input wire logic HREADY,                    // AHB bus ready
  output logic [31:0] HRDATA,                 // AHB read data
  output logic HREADYOUT,                     // AHB slave ready
  output logic HRESP,                         // AHB response, always OKAY
  input wire dem_pkg::dem_events_s EVENTS,    // Peripheral event pulses
  input wire dem_pkg::dem_chain_s CHAIN,      // Completion code pulse
  output logic [15:0] CH_TRIGGER              // Per-channel trigger pulses
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } dem_bus_e;

  dem_bus_e state_q;
  dem_bus_e state_d;
  logic [2:0] reg_sel_q;
  logic [2:0] reg_sel_d;
  logic ctrl_sel_q;
  logic ctrl_sel_d;
  logic [1:0] rd_idx_q;
  logic [1:0] rd_idx_d;
  logic mode_sel_q;
  logic mode_sel_d;
  logic hreadyout_q;
  logic hreadyout_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [15:0] trig_q;
  logic [15:0] trig_d;
  logic [2:0] wr_sel;
  logic [31:0] regs_rdata;
  logic [95:0] codes;
  logic [15:0] sel_hit;
  logic [15:0] fixed_hit;
  logic addr_phase;
  logic hresp_q;

  // Address decode, shared by read and write paths
  function automatic logic [3:0] decode_addr(input logic [31:0] a);
    case (a)
      dem_pkg::EVENT_MAP_CH0_3_ADDR: decode_addr = 4'h1;
      dem_pkg::EVENT_MAP_CH4_7_ADDR: decode_addr = 4'h2;
      dem_pkg::EVENT_MAP_CH12_15_ADDR: decode_addr = 4'h4;
      dem_pkg::MAPPER_CTRL_ADDR: decode_addr = 4'h8;
      default: decode_addr = 4'h0;
    endcase
  endfunction

  // Field position of the code for a non-chaining channel
  function automatic int field_base(input int ch);
    int r;
    r = (ch < 4) ? 0 : (ch < 8) ? 1 : 2;
    return r * 32 + (ch % 4) * dem_pkg::FIELD_STRIDE + dem_pkg::FIELD0_LSB;
  endfunction

  // Register index for read data; 3 selects no selector register and reads zero
  function automatic logic [1:0] read_index(input logic [3:0] d);
    if (d[0]) begin
      return 2'd0;
    end else if (d[1]) begin
      return 2'd1;
    end else if (d[2]) begin
      return 2'd2;
    end
    return 2'd3;
  endfunction

  dem_code_regs u_regs (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_sel(wr_sel),
    .wdata(HWDATA),
    .rd_idx(rd_idx_d), // Index of this address phase, so data stand before the wait ends
    .rdata(regs_rdata),
    .codes(codes)
  );

  // Fixed-mode defaults, one per peripheral channel
  assign fixed_hit = {EVENTS.serial1_rx_event, EVENTS.serial1_tx_event,
                      EVENTS.serial0_rx_event, EVENTS.serial0_tx_event,
                      4'h0,
                      EVENTS.gpio_pin7_event, EVENTS.gpio_pin6_event,
                      EVENTS.gpio_pin5_event, EVENTS.gpio_pin4_event,
                      EVENTS.sdram_refresh_event, EVENTS.timer_one_event,
                      EVENTS.timer_zero_event, EVENTS.host_port_event};

  // Every non-chaining channel decodes its own code, so shared codes fan out
  genvar gc;
  generate
    for (gc = 0; gc < dem_pkg::NUM_CH; gc++) begin : g_ch
      if (gc >= dem_pkg::CHAIN_FIRST && gc <= dem_pkg::CHAIN_LAST) begin : g_chain
        assign sel_hit[gc] = 1'b0;
      end else begin : g_periph
        dem_event_decode u_dec (
          .code(codes[field_base(gc) +: dem_pkg::CODE_W]),
          .events(EVENTS),
          .hit(sel_hit[gc])
        );
      end
    end
  endgenerate

  always_comb begin
    for (int c = 0; c < dem_pkg::NUM_CH; c++) begin
      if (c >= dem_pkg::CHAIN_FIRST && c <= dem_pkg::CHAIN_LAST) begin
        trig_d[c] = CHAIN.valid &&
                    (CHAIN.completion_code == 4'(c));
      end else begin
        trig_d[c] = mode_sel_q ? sel_hit[c] : fixed_hit[c];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      trig_q <= 16'h0000;
    end else begin
      trig_q <= trig_d;
    end
  end

  // Bus slave: writes land one cycle after the address phase,
  // reads need one wait cycle because register read data is registered
  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign wr_sel = (state_q == ST_WRITE) ? reg_sel_q : 3'b000;

  always_comb begin
    logic [3:0] dec;
    dec = decode_addr(HADDR);
    state_d = state_q;
    reg_sel_d = reg_sel_q;
    ctrl_sel_d = ctrl_sel_q;
    rd_idx_d = rd_idx_q;
    mode_sel_d = mode_sel_q;
    hreadyout_d = 1'b1;
    hrdata_d = hrdata_q;
    case (state_q)
      ST_IDLE: begin
        if (addr_phase) begin
          reg_sel_d = dec[2:0];
          ctrl_sel_d = dec[3];
          rd_idx_d = read_index(dec);
          if (HWRITE) begin
            state_d = ST_WRITE;
          end else begin
            state_d = ST_READ;
            hreadyout_d = 1'b0;
          end
        end
      end
      ST_WRITE: begin
        if (ctrl_sel_q) begin
          mode_sel_d = HWDATA[0];
        end
        state_d = ST_IDLE;
        if (addr_phase) begin
          reg_sel_d = dec[2:0];
          ctrl_sel_d = dec[3];
          rd_idx_d = read_index(dec);
          state_d = HWRITE ? ST_WRITE : ST_READ;
          hreadyout_d = HWRITE;
        end
      end
      ST_READ: begin
        // Registered regs data is valid now; unmapped reads give zero
        hrdata_d = ctrl_sel_q ? {31'h00000000, mode_sel_q} : regs_rdata;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      reg_sel_q <= 3'b000;
      ctrl_sel_q <= 1'b0;
      rd_idx_q <= 2'd3;
      mode_sel_q <= dem_pkg::MODE_SELECTABLE_RST;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      hresp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      reg_sel_q <= reg_sel_d;
      ctrl_sel_q <= ctrl_sel_d;
      rd_idx_q <= rd_idx_d;
      mode_sel_q <= mode_sel_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      // Error responses are never given; still a flop so every output is registered
      hresp_q <= 1'b0;
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hreadyout_q;
  assign HRESP = hresp_q;
  assign CH_TRIGGER = trig_q;

endmodule

`default_nettype wire

// ---- dem_mapper_checker.sv ----
/*
  Port assertions for the event channel mapper.
  Assumes one clock domain and HREADY looped back from HREADYOUT.
*/
`timescale 1ns/1ps
`default_nettype none

module dem_mapper_checker (
  input wire logic SYS_CLK,                // Clock
  input wire logic RST,                    // Sync reset
  input wire logic HSEL,                   // Select
  input wire logic [1:0] HTRANS,           // Transfer type
  input wire logic HWRITE,                 // Write
  input wire logic HREADY,                 // Bus ready
  input wire logic [31:0] HRDATA,          // Read data
  input wire logic HREADYOUT,              // Slave ready
  input wire logic HRESP,                  // Response
  input wire dem_pkg::dem_events_s EVENTS, // Event pulses
  input wire dem_pkg::dem_chain_s CHAIN,   // Completion pulse
  input wire logic [15:0] CH_TRIGGER       // Triggers
);
  logic rd_go;
  logic wr_go;
  logic [3:0] chain_hit;
  assign rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign wr_go = HSEL && HREADY && HTRANS[1] && HWRITE;
  // Only codes 8 to 11 may reach a chaining channel
  assign chain_hit = (CHAIN.valid && CHAIN.completion_code[3:2] == 2'b10) ?
    4'h1 << CHAIN.completion_code[1:0] : 4'h0;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  chain_map_a: assert property (!$past(RST) |-> CH_TRIGGER[11:8] == $past(chain_hit))
    else $error("chain trigger mismatch");
  no_event_a: assert property (!$past(RST) && $past(EVENTS) == 13'h0 && !$past(CHAIN.valid)
    |-> CH_TRIGGER == 16'h0)
    else $error("trigger without event");
  rd_wait_a: assert property (rd_go |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  wr_ready_a: assert property (wr_go |=> HREADYOUT)
    else $error("write stalled");
  resv_zero_a: assert property ((HRDATA & ~dem_pkg::FIELD_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  rdata_hold_a: assert property (HRDATA != $past(HRDATA) |-> !$past(HREADYOUT))
    else $error("read data changed outside a read");
  resp_okay_a: assert property (HRESP == 1'b0)
    else $error("response not okay");
  reset_idle_a: assert property ($past(RST) |-> CH_TRIGGER == 16'h0 && HREADYOUT)
    else $error("outputs not idle after reset");
endmodule

bind dem_mapper dem_mapper_checker chk_u (.SYS_CLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY,
  .HRDATA, .HREADYOUT, .HRESP, .EVENTS, .CHAIN, .CH_TRIGGER);

`default_nettype wire

// ---- dem_periph_model.sv ----
/*
  Peripheral side model: turns a one-cycle request into event and
  completion pulses. Assumes requests change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dem_periph_model (
  input wire logic clk,                       // Clock
  input wire logic rst,                       // Sync reset
  input wire logic go,                        // Fire request
  input wire dem_pkg::dem_events_s ev_req,    // Events to raise
  input wire dem_pkg::dem_chain_s ch_req,     // Completion to raise
  output var dem_pkg::dem_events_s events_q,  // Event pulses
  output var dem_pkg::dem_chain_s chain_q     // Completion pulse
);
  dem_pkg::dem_events_s events_d;
  dem_pkg::dem_chain_s chain_d;
  // Lines drop back low after one cycle, as edge-made interrupts do
  always_comb begin
    events_d = go ? ev_req : 13'h0;
    chain_d = go ? ch_req : 5'h0;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      events_q <= 13'h0;
      chain_q <= 5'h0;
    end else begin
      events_q <= events_d;
      chain_q <= chain_d;
    end
  end
endmodule

`default_nettype wire

// ---- dem_event_channel_mapper_tb.sv ----
/*
  Self-checking bench for the mapper: register rows, then mapping,
  reset and chaining cases. Assumes the mode register at 0x01a0ff10.
*/
`timescale 1ns/1ps
`default_nettype none

module dem_event_channel_mapper_tb;
  typedef struct {logic [31:0] a; logic [31:0] wd; logic [31:0] exp;} dem_row_s;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic go = 1'b0;
  dem_pkg::dem_events_s ev_req = 13'h0;
  dem_pkg::dem_chain_s ch_req = 5'h0;
  dem_pkg::dem_events_s EVENTS;
  dem_pkg::dem_chain_s CHAIN;
  logic [15:0] CH_TRIGGER;
  logic [31:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  // Unmapped slot first, then one row per selector register
  dem_row_s rows [4] = '{'{32'h01a0ff08, 32'h01010101, 32'h0},
    '{32'h01a0ff0c, 32'h01080901, 32'h01080901},
    '{32'h01a0ff04, 32'hc1c1ffc1, 32'h01013f01},
    '{32'h01a0ff00, 32'h0a0a0a0a, 32'h0a0a0a0a}};

  dem_mapper dut_u (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .EVENTS, .CHAIN, .CH_TRIGGER);
  dem_periph_model pm_u (.clk(SYS_CLK), .rst(RST), .go, .ev_req, .ch_req, .events_q(EVENTS),
    .chain_q(CHAIN));

  always #50 SYS_CLK = ~SYS_CLK;

  task report_and_stop;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is looked at in the settled half before the edge that samples it
  task wait_rdy;
    do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    @(posedge SYS_CLK);
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    wait_rdy;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy;
  endtask

  task pulse(input logic [12:0] e, input logic [4:0] c, input logic [15:0] exp);
    ev_req <= dem_pkg::dem_events_s'(e);
    ch_req <= dem_pkg::dem_chain_s'(c);
    go <= 1'b1;
    @(posedge SYS_CLK);
    go <= 1'b0;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk("trigger", {16'h0, exp}, {16'h0, CH_TRIGGER});
    @(posedge SYS_CLK);
  endtask

  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    chk("idle trigger", 32'h0, {16'h0, CH_TRIGGER});
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].wd);
      bus(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].exp, rd);
    end
    $display("test registers done");
    pulse(13'h100, 5'h0, 16'h000f);
    pulse(13'h002, 5'h19, 16'h92d0);
    bus(1'b1, 32'h01a0ff10, 32'h0);
    bus(1'b0, 32'h01a0ff10, 32'h0);
    chk("mode fixed", 32'h0, rd);
    pulse(13'h1fff, 5'h1b, 16'hf8ff);
    $display("test selection done");
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    for (int b = 0; b < 16; b += 4) begin
      if (b != 8) begin
        bus(1'b0, 32'h01a0ff00 + b, 32'h0);
        chk("default codes", 32'h03020100 + {4{8'(b)}}, rd);
      end
    end
    bus(1'b0, 32'h01a0ff10, 32'h0);
    chk("mode reset", 32'h1, rd);
    for (int i = 0; i < 13; i++) begin
      pulse(13'h1 << i, 5'h0, (i < 8) ? 16'h1 << i : (i == 8) ? 16'h0 : 16'h1 << (i + 3));
    end
    $display("test defaults done");
    for (int c = 0; c < 16; c++) begin
      pulse(13'h0, {1'b1, 4'(c)}, (c >= 8 && c <= 11) ? 16'h1 << c : 16'h0);
    end
    pulse(13'h0, 5'h08, 16'h0);
    $display("test chaining done");
    report_and_stop;
  end
endmodule

`default_nettype wire
